// ===== design/sramc_pkg.sv
// Package with timing constants and carrier types for the static RAM host
package sramc_pkg;

   // ------------------------------------------------------------------
   // Clock and geometry
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int WORD_IDX_W    = 12;
   localparam int WORD_COUNT    = 4096;

   // ------------------------------------------------------------------
   // Device timing in ns, commercial and military grades
   // ------------------------------------------------------------------
   localparam int T_ADDR_ACC_COM_NS  = 45;
   localparam int T_ADDR_ACC_MIL_NS  = 60;
   localparam int T_SEL_ACC_COM_NS   = 30;
   localparam int T_SEL_ACC_MIL_NS   = 35;
   localparam int T_SEL_OFF_COM_NS   = 35;
   localparam int T_SEL_OFF_MIL_NS   = 45;
   localparam int T_WR_OFF_COM_NS    = 35;
   localparam int T_WR_OFF_MIL_NS    = 45;
   localparam int T_WR_PULSE_COM_NS  = 30;
   localparam int T_WR_PULSE_MIL_NS  = 45;
   localparam int T_DAT_SETUP_COM_NS = 10;
   localparam int T_DAT_SETUP_MIL_NS = 15;
   localparam int T_DAT_HOLD_COM_NS  = 5;
   localparam int T_DAT_HOLD_MIL_NS  = 10;
   localparam int T_SEL_SETUP_COM_NS = 5;
   localparam int T_SEL_SETUP_MIL_NS = 10;
   localparam int T_SEL_HOLD_COM_NS  = 5;
   localparam int T_SEL_HOLD_MIL_NS  = 10;

   // Least times round up, at least one cycle
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // Worst-case (military) grade used for all counts
   localparam int RD_WAIT_CYC   = cyc_up(T_ADDR_ACC_MIL_NS);
   localparam int WR_SETUP_CYC  = cyc_up(T_SEL_SETUP_MIL_NS);
   localparam int WR_PULSE_CYC  = cyc_up(T_WR_PULSE_MIL_NS);
   localparam int WR_HOLD_CYC   = cyc_up(T_SEL_HOLD_MIL_NS);
   localparam int OFF_WAIT_CYC  = cyc_up(T_SEL_OFF_MIL_NS);
   localparam int CNT_W         = 4;

   // ------------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic                  wr;
      logic [WORD_IDX_W-1:0] idx;
      logic                  data;
   } sramc_req_t;

   typedef struct packed {
      logic [WORD_IDX_W-1:0] word_index;
      logic                  sel_n;
      logic                  wr_n;
      logic                  din;
   } sramc_pins_t;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_SETUP = 5'h02,
      ST_PULSE = 5'h04,
      ST_HOLD  = 5'h08,
      ST_READ  = 5'h10
   } sramc_state_t;

   typedef struct packed {
      sramc_state_t          st;
      logic [CNT_W-1:0]      cnt;
      sramc_pins_t           pins;
      logic                  ready;
      logic                  rd_valid;
      logic                  rd_data;
      logic                  bank_sel;
   } sramc_regs_t;

endpackage

// ===== design/sramc_host.sv
// Host controller driving one 4096 x 1 static RAM through its pins
module sramc_host
   import sramc_pkg::*;
#(
   parameter int BANK_BITS = 0
) (
   input  wire logic                            ref_clk_i,
   input  wire logic                            sys_rst_i,
   input  wire logic                            req_valid_i,
   input  wire sramc_req_t                      req_i,
   input  wire logic [(BANK_BITS>0?BANK_BITS:1)-1:0] req_bank_i,
   input  wire logic [(BANK_BITS>0?BANK_BITS:1)-1:0] my_bank_i,
   input  wire logic                            dout_i,
   output logic                                 req_ready_o,
   output logic                                 rd_valid_o,
   output logic                                 rd_data_o,
   output logic [WORD_IDX_W-1:0]                word_index_o,
   output logic                                 sel_n_o,
   output logic                                 wr_n_o,
   output logic                                 din_o
);

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (BANK_BITS < 0 || BANK_BITS > 8) begin : g_bad
      $error("BANK_BITS must lie in 0..8");
   end
   if (RD_WAIT_CYC + 2 >= (1 << CNT_W)) begin : g_cnt
      $error("Counter too narrow for read wait");
   end

   // ------------------------------------------------------------------
   // Input synchroniser for the data output pin
   // ------------------------------------------------------------------
   logic dout_meta_r;
   logic dout_sync_r;
   always_ff @(posedge ref_clk_i) begin
      dout_meta_r <= dout_i;
      dout_sync_r <= dout_meta_r;
   end

   // Bank match from the request bank and own bank inputs
   function automatic logic bank_hit(
      input logic [(BANK_BITS>0?BANK_BITS:1)-1:0] a,
      input logic [(BANK_BITS>0?BANK_BITS:1)-1:0] b);
      return (BANK_BITS == 0) ? 1'b1 : (a == b);
   endfunction

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   sramc_regs_t s_r;
   sramc_regs_t s_nxt;

   localparam logic [CNT_W-1:0] RD_LAST =
      CNT_W'(RD_WAIT_CYC + 2);
   localparam logic [CNT_W-1:0] SU_LAST = CNT_W'(WR_SETUP_CYC);
   localparam logic [CNT_W-1:0] PW_LAST = CNT_W'(WR_PULSE_CYC);
   localparam logic [CNT_W-1:0] HD_LAST = CNT_W'(WR_HOLD_CYC);
   localparam logic [CNT_W-1:0] OF_LAST = CNT_W'(OFF_WAIT_CYC);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   // Last cycle of a timed phase
   function automatic logic cnt_done(
      input logic [CNT_W-1:0] cnt,
      input logic [CNT_W-1:0] last);
      return (cnt + CNT_ONE) >= last;
   endfunction

   always_comb begin
      s_nxt          = s_r;
      s_nxt.rd_valid = 1'b0;
      s_nxt.cnt      = s_r.cnt + CNT_ONE;
      case (s_r.st)
         ST_IDLE: begin
            s_nxt.pins.sel_n = 1'b1;
            s_nxt.pins.wr_n  = 1'b1;
            // Wait for deselect float before next access
            if (s_r.cnt < OF_LAST) begin
               s_nxt.ready = 1'b0;
            end else if (s_r.ready && req_valid_i) begin
               s_nxt.ready           = 1'b0;
               s_nxt.cnt             = '0;
               // Full 12-bit word index, device decodes
               s_nxt.pins.word_index = req_i.idx;
               s_nxt.pins.din        = req_i.data;
               s_nxt.bank_sel        = bank_hit(req_bank_i, my_bank_i);
               // Select on a match of req_bank_i with my_bank_i, or on every request when BANK_BITS is 0
               s_nxt.pins.sel_n      = !bank_hit(req_bank_i, my_bank_i);
               s_nxt.st = req_i.wr ? ST_SETUP : ST_READ;
            end else begin
               // Counter saturates so ready never drops while idle
               s_nxt.ready = 1'b1;
               s_nxt.cnt   = s_r.cnt;
            end
         end
         ST_SETUP: begin
            // Select low before strobe falls
            if (cnt_done(s_r.cnt, SU_LAST)) begin
               s_nxt.pins.wr_n = !s_r.bank_sel;
               s_nxt.cnt       = '0;
               s_nxt.st        = ST_PULSE;
            end
         end
         ST_PULSE: begin
            // Strobe width, data setup, index stable
            // Index and data held throughout
            if (cnt_done(s_r.cnt, PW_LAST)) begin
               s_nxt.pins.wr_n = 1'b1;
               s_nxt.cnt       = '0;
               s_nxt.st        = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // Data and select held after strobe
            if (cnt_done(s_r.cnt, HD_LAST)) begin
               s_nxt.pins.sel_n = 1'b1;
               s_nxt.cnt        = '0;
               s_nxt.st         = ST_IDLE;
            end
         end
         ST_READ: begin
            // Wait access time plus synchroniser depth
            if (cnt_done(s_r.cnt, RD_LAST)) begin
               // Non-inverted data; open collector floats high
               s_nxt.rd_data    = s_r.bank_sel ? dout_sync_r : 1'b1;
               s_nxt.rd_valid   = 1'b1;
               s_nxt.pins.sel_n = 1'b1;
               s_nxt.cnt        = '0;
               s_nxt.st         = ST_IDLE;
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         s_r.st              <= ST_IDLE;
         s_r.cnt             <= '0;
         s_r.pins.word_index <= '0;
         s_r.pins.sel_n      <= 1'b1;
         s_r.pins.wr_n       <= 1'b1;
         s_r.pins.din        <= 1'b0;
         s_r.ready           <= 1'b0;
         s_r.rd_valid        <= 1'b0;
         s_r.rd_data         <= 1'b0;
         s_r.bank_sel        <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Outputs, all from flip-flops; device output is off while writing
   // and reads only occur with the strobe high
   // ------------------------------------------------------------------
   assign req_ready_o  = s_r.ready;
   assign rd_valid_o   = s_r.rd_valid;
   assign rd_data_o    = s_r.rd_data;
   assign word_index_o = s_r.pins.word_index;
   assign sel_n_o      = s_r.pins.sel_n;
   assign wr_n_o       = s_r.pins.wr_n;
   assign din_o        = s_r.pins.din;

endmodule

// ===== verif/sramc_host_monitor.sv
// Checker of pin timing for the static RAM host
module sramc_host_monitor
   import sramc_pkg::*;
#(
   parameter int BANK_BITS = 0
) (
   input wire logic                  ref_clk_i,
   input wire logic                  sys_rst_i,
   input wire logic                  req_valid_i,
   input wire sramc_req_t            req_i,
   input wire logic [(BANK_BITS>0?BANK_BITS:1)-1:0] req_bank_i,
   input wire logic [(BANK_BITS>0?BANK_BITS:1)-1:0] my_bank_i,
   input wire logic                  req_ready_o,
   input wire logic                  rd_valid_o,
   input wire logic [WORD_IDX_W-1:0] word_index_o,
   input wire logic                  sel_n_o,
   input wire logic                  wr_n_o,
   input wire logic                  din_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire logic sel_hit = (BANK_BITS == 0) || (req_bank_i == my_bank_i);
   wire logic rd_take = req_valid_i && req_ready_o && !req_i.wr;
   property p_wr_pulse; $fell(wr_n_o) |-> !wr_n_o[*3] ##1 wr_n_o; endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write strobe width wrong");
   property p_sel_setup; $fell(wr_n_o) |-> $past(!sel_n_o); endproperty
   a_sel_setup: assert property (p_sel_setup)
      else $error("select not set up before strobe");
   property p_sel_hold; $rose(wr_n_o) |-> !sel_n_o; endproperty
   a_sel_hold: assert property (p_sel_hold)
      else $error("select released with strobe");
   property p_din; (!wr_n_o || $rose(wr_n_o)) |-> $stable(din_o); endproperty
   a_din: assert property (p_din)
      else $error("data moved around strobe");
   property p_idx; !wr_n_o |-> $stable(word_index_o); endproperty
   a_idx: assert property (p_idx)
      else $error("index moved during strobe");
   property p_wr_sel; !wr_n_o |-> !sel_n_o; endproperty
   a_wr_sel: assert property (p_wr_sel)
      else $error("strobe while deselected");
   property p_rd_lat; rd_take |-> !rd_valid_o[*6] ##1 rd_valid_o; endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read answer too early");
   property p_rd_sel;
      rd_take && sel_hit |=> (!sel_n_o && wr_n_o)[*5];
   endproperty
   a_rd_sel: assert property (p_rd_sel)
      else $error("read select or strobe wrong");
   property p_miss;
      req_valid_i && req_ready_o && !sel_hit |=> (sel_n_o && wr_n_o)[*5];
   endproperty
   a_miss: assert property (p_miss)
      else $error("pins moved on bank miss");
   c_miss: cover property (req_valid_i && req_ready_o && !sel_hit);
   c_rd: cover property (rd_take);
   c_wr: cover property (req_valid_i && req_ready_o && req_i.wr);
   c_strobe: cover property ($rose(wr_n_o));
endmodule

bind sramc_host sramc_host_monitor #(.BANK_BITS(BANK_BITS)) mon_u (
   .ref_clk_i, .sys_rst_i, .req_bank_i, .my_bank_i,
   .req_valid_i, .req_i, .req_ready_o, .rd_valid_o, .word_index_o,
   .sel_n_o, .wr_n_o, .din_o);

// ===== verif/sramc_ram_model.sv
// Behavioural 4096 x 1 RAM, open-collector output with pull-up
module sramc_ram_model
   import sramc_pkg::*;
#(
   parameter int ACC_NS = 40
) (
   input  wire logic [WORD_IDX_W-1:0] word_index_i,
   input  wire logic                  sel_n_i,
   input  wire logic                  wr_n_i,
   input  wire logic                  din_i,
   output logic                       dout_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mem [WORD_COUNT];
   logic rd_bit;
   initial for (int i = 0; i < WORD_COUNT; i++) mem[i] = i[0];
   always @* begin
      if (!sel_n_i && !wr_n_i) mem[word_index_i] = din_i;
   end
   // Off reads as the pull-up level
   assign rd_bit = (!sel_n_i && wr_n_i) ? mem[word_index_i] : 1'b1;
   assign #(ACC_NS) dout_o = rd_bit;
endmodule

// ===== verif/test_sramc_host.sv
// Self-checking bench for the static RAM host with a RAM model
module test_sramc_host
   import sramc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic                  clk = 1'b0, rst = 1'b1, vld = 1'b0, bank = 1'b1;
   logic                  rdy, rv, rd, sn, wn, di, dout;
   logic [WORD_IDX_W-1:0] idx;
   sramc_req_t            req = '0;
   int                    err_count = 0, checks = 0, cycles = 0;
   initial forever #(CLK_PERIOD_NS / 2) clk = ~clk;
   sramc_host #(.BANK_BITS(1)) dut_u (.ref_clk_i(clk), .sys_rst_i(rst),
      .req_valid_i(vld),
      .req_i(req), .req_bank_i(bank), .my_bank_i(1'b1), .dout_i(dout),
      .req_ready_o(rdy), .rd_valid_o(rv), .rd_data_o(rd),
      .word_index_o(idx), .sel_n_o(sn), .wr_n_o(wn), .din_o(di));
   sramc_ram_model #(.ACC_NS(58)) ram_u (.word_index_i(idx),
      .sel_n_i(sn), .wr_n_i(wn), .din_i(di), .dout_o(dout));
   task automatic chk(input string nm, input logic [11:0] s, e);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic finish_test();
      $display("Checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         finish_test();
      end
   end
   // Holds the request until a ready edge takes it
   task automatic access(input logic w, input logic [11:0] a, input logic d);
      @(negedge clk);
      vld = 1'b1;
      req = '{wr: w, idx: a, data: d};
      while (rdy !== 1'b1) @(negedge clk);
      @(negedge clk);
      vld = 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic e);
      int lat;
      access(1'b0, a, 1'b0);
      lat = 0;
      while (rv !== 1'b1 && lat < 20) begin
         @(negedge clk);
         lat++;
      end
      chk("read latency", lat[11:0], 12'(RD_WAIT_CYC + 2));
      chk("read data", rd, e);
   endtask
   task automatic t_corners();
      logic [11:0] a [5] = '{12'h000, 12'hfff, 12'h555, 12'haaa, 12'h800};
      for (int i = 0; i < 5; i++) access(1'b1, a[i], i[0] == 0);
      for (int i = 0; i < 5; i++) rd_chk(a[i], i[0] == 0);
   endtask
   task automatic t_overwrite();
      for (int b = 0; b < 2; b++) begin
         access(1'b1, 12'hfff, b[0]);
         rd_chk(12'hfff, b[0]);
      end
   endtask
   // A miss must neither write nor drive; the read sees the pull-up
   task automatic t_bank_miss();
      bank = 1'b0;
      access(1'b1, 12'haaa, 1'b1);
      rd_chk(12'haaa, 1'b1);
      bank = 1'b1;
      rd_chk(12'haaa, 1'b0);
   endtask
   task automatic t_reset_mid();
      access(1'b1, 12'h555, 1'b0);
      @(negedge clk);
      rst = 1'b1;
      repeat (3) @(negedge clk);
      chk("select", sn, 1'b1);
      chk("data out", dout, 1'b1);
      rst = 1'b0;
      rd_chk(12'h800, 1'b1);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_corners();
      t_overwrite();
      t_bank_miss();
      t_reset_mid();
      finish_test();
   end
endmodule
